/* File: aiopc_pkg.sv */
// package of register map, field layouts and defaults for the axis protection block
package aiopc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_PULSE_FMT  = 8'h00;
  localparam logic [7:0] ADDR_ALARM      = 8'h04;
  localparam logic [7:0] ADDR_INPOS      = 8'h08;
  localparam logic [7:0] ADDR_CLEAR      = 8'h0c;
  localparam logic [7:0] ADDR_ENDLIM     = 8'h10;
  localparam logic [7:0] ADDR_SOFTCTL    = 8'h14;
  localparam logic [7:0] ADDR_NEG_POS    = 8'h18;
  localparam logic [7:0] ADDR_POS_POS    = 8'h1c;
  localparam logic [7:0] ADDR_HOME       = 8'h20;
  localparam logic [7:0] ADDR_BL_CTL     = 8'h24;
  localparam logic [7:0] ADDR_BL_RATE    = 8'h28;
  localparam logic [7:0] ADDR_STATUS     = 8'h2c;
  localparam logic [7:0] ADDR_POSITION   = 8'h30;

  // pulse output format codes
  localparam logic [9:0] FMT_SD_NORM    = 10'h001;
  localparam logic [9:0] FMT_SD_PULSE_N = 10'h002;
  localparam logic [9:0] FMT_SD_DIR_N   = 10'h004;
  localparam logic [9:0] FMT_SD_BOTH_N  = 10'h008;
  localparam logic [9:0] FMT_CW_NORM    = 10'h010;
  localparam logic [9:0] FMT_CW_BOTH_N  = 10'h020;
  localparam logic [9:0] FMT_CW_FIRST_N = 10'h100;
  localparam logic [9:0] FMT_CW_SECOND_N = 10'h200;

  // control field positions
  localparam int BIT_ENABLE   = 0;
  localparam int BIT_POLARITY = 1;
  localparam int BIT_REACTION = 2;
  localparam int BIT_NEG_EN   = 0;
  localparam int BIT_POS_EN   = 1;
  localparam int BIT_NEG_REACT = 2;
  localparam int BIT_POS_REACT = 3;
  localparam int BIT_HOME_CLR = 0;
  localparam int BIT_HOME_REACT = 1;
  localparam int BIT_ORIGIN_POL = 2;
  localparam int BIT_IDX_POL  = 3;

  // reset values
  localparam logic [2:0]  ALARM_RST   = 3'h6; // disabled, high active, decelerate
  localparam logic [1:0]  INPOS_RST   = 2'h2; // disabled, high active
  localparam logic [2:0]  CLEAR_RST   = 3'h3; // polarity high, mode 1
  localparam logic [2:0]  ENDLIM_RST  = 3'h7; // enabled, high active, decelerate
  localparam logic [3:0]  SOFT_RST    = 4'hc; // both off, both decelerate
  localparam logic [3:0]  HOME_RST    = 4'hc; // origin/index high active
  localparam logic [11:0] BL_MAX      = 12'hfff;
  localparam logic [1:0]  CLR_MODE_HOME = 2'h1;

  // clear pulse length and rate divider reference
  localparam int CLK_HZ = 100_000_000;
  localparam int CLEAR_PULSE_NS = 1000;
  localparam int CLEAR_CYCLES = (CLEAR_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // stop request: immediate or decelerating
  typedef struct packed {
    logic immediate;
    logic decel;
  } aiopc_stop_s;

  // motion state of the pulse sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_COMP = 3'b010,
    ST_CMD  = 3'b100
  } aiopc_state_e;
endpackage

/* File: aiopc_axis.sv */
// axis pulse formatting, limit and alarm stops, homing actions and backlash compensation
`timescale 1ns/10ps
module aiopc_axis
  import aiopc_pkg::*;
(
  input  wire logic        clk,          // 100 MHz clock
  input  wire logic        rst,          // synchronous reset, active high
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb enable
  input  wire logic        pwrite,       // apb direction
  input  wire logic [7:0]  paddr,        // apb byte address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic      [31:0] prdata,       // apb read data
  output logic             pready,       // apb ready
  output logic             pslverr,      // apb error on unmapped address
  input  wire logic        cmdPulse,     // command pulse request, one cycle
  input  wire logic        cmdDir,       // commanded direction, 1 positive
  input  wire logic        homeDone,     // homing finished, one cycle
  input  wire logic        driveAlarm,   // raw alarm pin
  input  wire logic        endLimit,     // raw end limit pin
  input  wire logic        inPosition,   // raw in-position pin
  input  wire logic        originSensor, // raw origin pin
  input  wire logic        encoderIndex, // raw index pin
  output logic             pulseA,       // pulse or cw line
  output logic             pulseB,       // direction or ccw line
  output logic             counterClear, // deviation counter clear output
  output logic             stopNow,      // immediate stop request
  output logic             stopDecel,    // decelerating stop request
  output logic             originActive, // origin after polarity
  output logic             indexActive,  // index after polarity
  output logic             inPosOk,      // in-position reached
  output logic             cmdReady      // sequencer accepts command pulse
);

  logic [9:0]         pulseFmt;
  logic [2:0]         alarmCfg;
  logic [1:0]         inposCfg;
  logic [2:0]         clearCfg;
  logic [2:0]         endCfg;
  logic [3:0]         softCfg;
  logic signed [31:0] negLimit;
  logic signed [31:0] posLimit;
  logic [3:0]         homeCfg;
  logic               blEnable;
  logic [11:0]        blCount;
  logic [31:0]        blRate;
  logic signed [31:0] position;
  logic [7:0]         clearCnt;
  logic [11:0]        compLeft;
  logic [31:0]        rateAcc;
  logic               lastDir;
  logic               pulsePhase;
  logic               pulseDir;
  aiopc_state_e       state;
  aiopc_stop_s        next_stop;

  logic alarmHit, endHit, negHit, posHit, wr, rd, mapped, homeStop, rateTick;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  // polarity applied before any use of the pins
  assign alarmHit = alarmCfg[BIT_ENABLE] &&
                    (driveAlarm == alarmCfg[BIT_POLARITY]);
  assign endHit   = endCfg[BIT_ENABLE] &&
                    (endLimit == endCfg[BIT_POLARITY]);
  assign negHit = softCfg[BIT_NEG_EN] && !cmdDir && (position <= negLimit);
  assign posHit = softCfg[BIT_POS_EN] && cmdDir && (position >= posLimit);
  assign homeStop = homeDone;

  // address decode, answered in the access cycle with no wait
  always_comb begin
    if (paddr == ADDR_PULSE_FMT || paddr == ADDR_ALARM || paddr == ADDR_INPOS ||
        paddr == ADDR_CLEAR || paddr == ADDR_ENDLIM || paddr == ADDR_SOFTCTL) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_NEG_POS || paddr == ADDR_POS_POS || paddr == ADDR_HOME ||
                 paddr == ADDR_BL_CTL || paddr == ADDR_BL_RATE) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_STATUS || paddr == ADDR_POSITION) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // ready rises in setup so the access completes at its first edge
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

  // configuration writes; unsupported codes are ignored and old value kept
  always_ff @(posedge clk) begin
    if (rst) begin
      pulseFmt <= FMT_CW_NORM;
      alarmCfg <= ALARM_RST;
      inposCfg <= INPOS_RST;
      clearCfg <= CLEAR_RST;
      endCfg   <= ENDLIM_RST;
      softCfg  <= SOFT_RST;
      negLimit <= 32'sh0000_0000;
      posLimit <= 32'sh0000_0000;
      homeCfg  <= HOME_RST;
      blEnable <= 1'b0;
      blCount  <= 12'h000;
      blRate   <= 32'h0000_0000;
    end else if (wr && pready) begin
      if (paddr == ADDR_PULSE_FMT) begin
        if (pwdata[9:0] == FMT_SD_NORM || pwdata[9:0] == FMT_SD_PULSE_N ||
            pwdata[9:0] == FMT_SD_DIR_N || pwdata[9:0] == FMT_SD_BOTH_N ||
            pwdata[9:0] == FMT_CW_NORM || pwdata[9:0] == FMT_CW_BOTH_N ||
            pwdata[9:0] == FMT_CW_FIRST_N || pwdata[9:0] == FMT_CW_SECOND_N) begin
          pulseFmt <= pwdata[9:0];
        end
      end else if (paddr == ADDR_ALARM) begin
        alarmCfg <= pwdata[2:0];
      end else if (paddr == ADDR_INPOS) begin
        inposCfg <= pwdata[1:0];
      end else if (paddr == ADDR_CLEAR) begin
        clearCfg[0] <= pwdata[0];
        if (pwdata[2:1] <= CLR_MODE_HOME) begin
          clearCfg[2:1] <= pwdata[2:1];
        end
      end else if (paddr == ADDR_ENDLIM) begin
        endCfg <= pwdata[2:0];
      end else if (paddr == ADDR_SOFTCTL) begin
        softCfg <= pwdata[3:0];
      end else if (paddr == ADDR_NEG_POS) begin
        negLimit <= $signed(pwdata);
      end else if (paddr == ADDR_POS_POS) begin
        posLimit <= $signed(pwdata);
      end else if (paddr == ADDR_HOME) begin
        homeCfg <= pwdata[3:0];
      end else if (paddr == ADDR_BL_CTL) begin
        blEnable <= pwdata[0];
        blCount  <= pwdata[27:16];
      end else if (paddr == ADDR_BL_RATE) begin
        blRate <= pwdata;
      end
    end
  end

  // read mux, registered at setup so data is valid in the access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      if (paddr == ADDR_PULSE_FMT) begin
        prdata <= {22'h000000, pulseFmt};
      end else if (paddr == ADDR_ALARM) begin
        prdata <= {29'h0000000, alarmCfg};
      end else if (paddr == ADDR_INPOS) begin
        prdata <= {30'h00000000, inposCfg};
      end else if (paddr == ADDR_CLEAR) begin
        prdata <= {29'h0000000, clearCfg};
      end else if (paddr == ADDR_ENDLIM) begin
        prdata <= {29'h0000000, endCfg};
      end else if (paddr == ADDR_SOFTCTL) begin
        prdata <= {28'h0000000, softCfg};
      end else if (paddr == ADDR_NEG_POS) begin
        prdata <= negLimit;
      end else if (paddr == ADDR_POS_POS) begin
        prdata <= posLimit;
      end else if (paddr == ADDR_HOME) begin
        prdata <= {28'h0000000, homeCfg};
      end else if (paddr == ADDR_BL_CTL) begin
        prdata <= {4'h0, blCount, 15'h0000, blEnable};
      end else if (paddr == ADDR_BL_RATE) begin
        prdata <= blRate;
      end else if (paddr == ADDR_STATUS) begin
        prdata <= {25'h0000000, state, stopDecel, stopNow, inPosOk, counterClear};
      end else if (paddr == ADDR_POSITION) begin
        prdata <= position;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // stop priority: any immediate source wins over a decelerating one
  always_comb begin
    next_stop = '0;
    if (alarmHit) begin
      if (alarmCfg[BIT_REACTION]) next_stop.decel = 1'b1;
      else next_stop.immediate = 1'b1;
    end
    if (endHit) begin
      if (endCfg[BIT_REACTION]) next_stop.decel = 1'b1;
      else next_stop.immediate = 1'b1;
    end
    if (negHit) begin
      if (softCfg[BIT_NEG_REACT]) next_stop.decel = 1'b1;
      else next_stop.immediate = 1'b1;
    end
    if (posHit) begin
      if (softCfg[BIT_POS_REACT]) next_stop.decel = 1'b1;
      else next_stop.immediate = 1'b1;
    end
    if (homeStop) begin
      if (homeCfg[BIT_HOME_REACT]) next_stop.decel = 1'b1;
      else next_stop.immediate = 1'b1;
    end
    if (next_stop.immediate) next_stop.decel = 1'b0;
  end

  // stop outputs and polarity-corrected sensor levels
  always_ff @(posedge clk) begin
    if (rst) begin
      stopNow      <= 1'b0;
      stopDecel    <= 1'b0;
      originActive <= 1'b0;
      indexActive  <= 1'b0;
      inPosOk      <= 1'b0;
    end else begin
      stopNow      <= next_stop.immediate;
      stopDecel    <= next_stop.decel;
      originActive <= (originSensor == homeCfg[BIT_ORIGIN_POL]);
      indexActive  <= (encoderIndex == homeCfg[BIT_IDX_POL]);
      inPosOk <= !inposCfg[BIT_ENABLE] ||
                 (inPosition == inposCfg[BIT_POLARITY]);
    end
  end

  // counter clear pulse of fixed length after homing
  always_ff @(posedge clk) begin
    if (rst) begin
      clearCnt     <= 8'h00;
      counterClear <= 1'b0;
    end else begin
      if (homeDone && clearCfg[2:1] == CLR_MODE_HOME) begin
        clearCnt <= 8'(CLEAR_CYCLES);
      end else if (clearCnt != 8'h00) begin
        clearCnt <= clearCnt - 8'h01;
      end
      counterClear <= (clearCnt != 8'h00) ~^ clearCfg[0];
    end
  end

  // rate divider for corrective pulses: accumulate rate per cycle against clock
  assign rateTick = (rateAcc + blRate) >= 32'(CLK_HZ);
  always_ff @(posedge clk) begin
    if (rst || state != ST_COMP) begin
      rateAcc <= 32'h0000_0000;
    end else if (rateTick) begin
      rateAcc <= rateAcc + blRate - 32'(CLK_HZ);
    end else begin
      rateAcc <= rateAcc + blRate;
    end
  end

  // sequencer: compensation pulses come first after a reversal
  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= ST_IDLE;
      compLeft   <= 12'h000;
      lastDir    <= 1'b1;
      pulsePhase <= 1'b0;
      pulseDir   <= 1'b1;
      position   <= 32'sh0000_0000;
    end else begin
      pulsePhase <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cmdPulse && !next_stop.immediate) begin
            pulseDir <= cmdDir;
            lastDir  <= cmdDir;
            if (blEnable && cmdDir != lastDir && blCount != 12'h000) begin
              compLeft <= blCount;
              state    <= ST_COMP;
            end else begin
              state <= ST_CMD;
            end
          end
        end
        ST_COMP: begin
          if (next_stop.immediate) begin
            state <= ST_IDLE;
          end else if (compLeft == 12'h000) begin
            state <= ST_CMD; // one low cycle keeps the last corrective pulse apart
          end else if (rateTick) begin
            pulsePhase <= 1'b1;
            compLeft   <= compLeft - 12'h001;
          end
        end
        ST_CMD: begin
          if (!next_stop.immediate) begin
            pulsePhase <= 1'b1;
            position <= pulseDir ? position + 32'sh1 : position - 32'sh1;
          end
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      if (homeDone && homeCfg[BIT_HOME_CLR]) position <= 32'sh0000_0000;
    end
  end

  // ready decodes the sequencer's next state, so it is high exactly while idle
  always_ff @(posedge clk) begin
    if (rst) cmdReady <= 1'b1;
    else cmdReady <= (state == ST_IDLE && !(cmdPulse && !next_stop.immediate)) ||
                     state == ST_CMD || (state == ST_COMP && next_stop.immediate);
  end

  // line formatting per selected output style
  always_ff @(posedge clk) begin
    if (rst) begin
      pulseA <= 1'b0;
      pulseB <= 1'b0;
    end else begin
      case (pulseFmt)
        FMT_SD_NORM:     begin pulseA <= pulsePhase;  pulseB <= pulseDir;  end
        FMT_SD_PULSE_N:  begin pulseA <= !pulsePhase; pulseB <= pulseDir;  end
        FMT_SD_DIR_N:    begin pulseA <= pulsePhase;  pulseB <= !pulseDir; end
        FMT_SD_BOTH_N:   begin pulseA <= !pulsePhase; pulseB <= !pulseDir; end
        FMT_CW_BOTH_N: begin
          pulseA <= !(pulsePhase && pulseDir);
          pulseB <= !(pulsePhase && !pulseDir);
        end
        FMT_CW_FIRST_N: begin
          pulseA <= !(pulsePhase && pulseDir);
          pulseB <= pulsePhase && !pulseDir;
        end
        FMT_CW_SECOND_N: begin
          pulseA <= pulsePhase && pulseDir;
          pulseB <= !(pulsePhase && !pulseDir);
        end
        default: begin
          pulseA <= pulsePhase && pulseDir;
          pulseB <= pulsePhase && !pulseDir;
        end
      endcase
    end
  end

  // checks on stop, clear, compensation and origin polarity behaviour
  a_alarm_off_quiet: assert property (@(posedge clk) disable iff (rst)
    !alarmCfg[BIT_ENABLE] && !endHit && !negHit && !posHit && !homeStop |=> !stopNow && !stopDecel)
    else $error("stop raised with no enabled source");
  a_alarm_immediate: assert property (@(posedge clk) disable iff (rst)
    alarmHit && !alarmCfg[BIT_REACTION] |=> stopNow)
    else $error("alarm immediate stop missing");
  a_end_limit_stop: assert property (@(posedge clk) disable iff (rst)
    endHit |=> stopNow || stopDecel)
    else $error("end limit produced no stop");
  a_soft_limit_pos: assert property (@(posedge clk) disable iff (rst)
    posHit && !softCfg[BIT_POS_REACT] |=> stopNow)
    else $error("positive soft limit not stopping");
  a_clear_pulse_home: assert property (@(posedge clk) disable iff (rst)
    homeDone && clearCfg == CLEAR_RST |=> ##1 counterClear)
    else $error("clear pulse missing after homing");
  a_home_pos_clear: assert property (@(posedge clk) disable iff (rst)
    homeDone && homeCfg[BIT_HOME_CLR] |=> position == 32'sh0)
    else $error("position not cleared after homing");
  a_comp_first: assert property (@(posedge clk) disable iff (rst)
    state == ST_IDLE && cmdPulse && !next_stop.immediate && blEnable &&
    cmdDir != lastDir && blCount != 12'h000 |=> state == ST_COMP)
    else $error("reversal skipped compensation");
  a_origin_pol: assert property (@(posedge clk) disable iff (rst)
    ##1 originActive == ($past(originSensor) == $past(homeCfg[BIT_ORIGIN_POL])))
    else $error("origin polarity wrong");
  c_comp_run: cover property (@(posedge clk) state == ST_COMP ##[1:50] state == ST_CMD);
  c_decel: cover property (@(posedge clk) stopDecel);
  c_clear: cover property (@(posedge clk) homeDone ##2 counterClear);
endmodule

/* File: aiopc_drive_model.sv */
// behavioural drive and sensor model: raw pins and pulse edge counters
`timescale 1ns/10ps
module aiopc_drive_model
  import aiopc_pkg::*;
(
  input  wire logic        clk,          // bench clock
  input  wire logic        rst,          // synchronous reset, active high
  input  wire logic        pulseA,       // pulse or cw line
  input  wire logic        pulseB,       // direction or ccw line
  input  wire logic [4:0]  pinLevel,     // commanded raw pin levels
  output logic             driveAlarm,   // alarm pin
  output logic             endLimit,     // end limit pin
  output logic             inPosition,   // in-position pin
  output logic             originSensor, // origin pin
  output logic             encoderIndex, // index pin
  output logic      [15:0] cntA,         // rising edges on pulseA
  output logic      [15:0] cntB          // rising edges on pulseB
);
  logic lastA;
  logic lastB;
  // pins are plain levels so a fault can be raised or dropped at any cycle
  assign {driveAlarm, endLimit, inPosition, originSensor, encoderIndex} = pinLevel;
  // format changes also make edges, so users work on count differences
  always_ff @(posedge clk) begin
    lastA <= pulseA;
    lastB <= pulseB;
    if (rst) begin
      cntA <= 16'h0;
      cntB <= 16'h0;
    end else begin
      cntA <= cntA + 16'(pulseA & ~lastA);
      cntB <= cntB + 16'(pulseB & ~lastB);
    end
  end
endmodule

/* File: axis_io_protection_config_bench.sv */
// self-checking bench for the axis protection block
`timescale 1ns/10ps
module axis_io_protection_config_bench import aiopc_pkg::*; ;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic        pready, pslverr, rerr;
  logic        cmdPulse = 1'b0, cmdDir = 1'b1, homeDone = 1'b0;
  logic [4:0]  pinLevel = 5'h0;
  logic        driveAlarm, endLimit, inPosition, originSensor, encoderIndex;
  logic        pulseA, pulseB, counterClear, stopNow, stopDecel;
  logic        originActive, indexActive, inPosOk, cmdReady;
  logic [15:0] cntA, cntB;
  int          fails = 0, total_checks = 0;
  logic [9:0]  fmt [8] = '{FMT_SD_NORM, FMT_SD_PULSE_N, FMT_SD_DIR_N, FMT_SD_BOTH_N,
                           FMT_CW_NORM, FMT_CW_BOTH_N, FMT_CW_FIRST_N, FMT_CW_SECOND_N};
  logic [7:0]  idleA = 8'b0110_1010;     // bit i: idle pulseA for fmt[i]
  logic [7:0]  idleB = 8'b1010_0000;     // bit i: idle pulseB for cw/ccw codes
  logic [7:0]  rstAddr [9] = '{ADDR_PULSE_FMT, ADDR_ALARM, ADDR_INPOS, ADDR_CLEAR,
                               ADDR_ENDLIM, ADDR_SOFTCTL, ADDR_HOME, ADDR_BL_CTL, ADDR_BL_RATE};
  logic [31:0] rstVal [9] = '{32'h10, 32'h6, 32'h2, 32'h3, 32'h7, 32'hc, 32'hc, 32'h0, 32'h0};

  always #5 clk = ~clk;

  aiopc_axis i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmdPulse(cmdPulse), .cmdDir(cmdDir), .homeDone(homeDone), .driveAlarm(driveAlarm),
    .endLimit(endLimit), .inPosition(inPosition), .originSensor(originSensor),
    .encoderIndex(encoderIndex), .pulseA(pulseA), .pulseB(pulseB),
    .counterClear(counterClear), .stopNow(stopNow), .stopDecel(stopDecel),
    .originActive(originActive), .indexActive(indexActive), .inPosOk(inPosOk),
    .cmdReady(cmdReady));
  aiopc_drive_model i_drive (.clk(clk), .rst(rst), .pulseA(pulseA), .pulseB(pulseB),
    .pinLevel(pinLevel), .driveAlarm(driveAlarm), .endLimit(endLimit),
    .inPosition(inPosition), .originSensor(originSensor), .encoderIndex(encoderIndex),
    .cntA(cntA), .cntB(cntB));

  task automatic print_verdict();
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chkW(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkB(input logic got, input logic exp);
    chkW({31'h0, got}, {31'h0, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer, entered just after a rising edge; waits for pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n == 50) fails++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chkW(rdata, exp);
  endtask
  // pins: 4 alarm, 3 end limit, 2 in-position, 1 origin, 0 index; then stops after settling
  task automatic pins(input logic [4:0] p, input logic now, input logic dec);
    pinLevel <= p;
    tick(3);
    chkB(stopNow, now);
    chkB(stopDecel, dec);
  endtask
  // one command pulse, then the edge counts expected on each line
  task automatic go(input logic dir, input logic [15:0] da, input logic [15:0] db);
    logic [15:0] a0, b0;
    int n;
    a0 = cntA; b0 = cntB;
    chkB(cmdReady, 1'b1);
    cmdDir <= dir; cmdPulse <= 1'b1;
    @(posedge clk);
    cmdPulse <= 1'b0;
    tick(1);
    chkB(cmdReady, 1'b0);
    n = 0;
    while ((cntA - a0 !== da || cntB - b0 !== db) && n < 1000) begin @(posedge clk); n++; end
    tick(20);
    chkW({cntA - a0, cntB - b0}, {da, db});
  endtask

  initial begin
    #200000;
    fails++;
    print_verdict();
  end

  initial begin
    tick(6);
    rst <= 1'b0;
    tick(1);
    for (int i = 0; i < 5; i++) begin
      rd(rstAddr[i], rstVal[i]);
    end
    for (int i = 5; i < 9; i++) begin
      rd(rstAddr[i], rstVal[i]);
    end
    rd(8'h3c, 32'h0);
    chkB(rerr, 1'b1);
    pins(5'h12, 1'b0, 1'b0);
    chkB(inPosOk, 1'b1);
    chkB(originActive, 1'b1);
    wr(ADDR_ALARM, 32'h2);
    wr(ADDR_ALARM, 32'h3);
    pins(5'h12, 1'b1, 1'b0);
    wr(ADDR_ALARM, 32'h2);
    wr(ADDR_ALARM, 32'h0);
    wr(ADDR_ALARM, 32'h1);
    pins(5'h12, 1'b0, 1'b0);
    pins(5'h02, 1'b1, 1'b0);
    wr(ADDR_ALARM, 32'h6);
    pins(5'h0a, 1'b0, 1'b1);
    wr(ADDR_ENDLIM, 32'h0);
    pins(5'h0a, 1'b0, 1'b0);
    wr(ADDR_ENDLIM, 32'h1);
    pins(5'h0a, 1'b0, 1'b0);
    pins(5'h02, 1'b1, 1'b0);
    wr(ADDR_ENDLIM, 32'h7);
    wr(ADDR_INPOS, 32'h3);
    tick(1);
    chkB(inPosOk, 1'b0);
    pins(5'h06, 1'b0, 1'b0);
    chkB(inPosOk, 1'b1);
    wr(ADDR_HOME, 32'h8);
    pins(5'h03, 1'b0, 1'b0);
    chkB(originActive, 1'b0);
    chkB(indexActive, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_PULSE_FMT, {22'h0, fmt[i]});
      tick(3);
      chkB(pulseA, idleA[i]);
      if (i >= 4) chkB(pulseB, idleB[i]);
    end
    wr(ADDR_PULSE_FMT, 32'h3);
    rd(ADDR_PULSE_FMT, {22'h0, FMT_CW_SECOND_N});
    wr(ADDR_PULSE_FMT, 32'h10);
    go(1'b1, 16'h1, 16'h0);
    go(1'b0, 16'h0, 16'h1);
    wr(ADDR_BL_CTL, 32'h0003_0001);
    wr(ADDR_BL_RATE, 32'd10_000_000);
    go(1'b1, 16'h4, 16'h0);
    rd(ADDR_POSITION, 32'h1);
    wr(ADDR_POS_POS, 32'h1);
    wr(ADDR_SOFTCTL, 32'h2);
    pins(5'h00, 1'b1, 1'b0);
    cmdDir <= 1'b0;
    pins(5'h00, 1'b0, 1'b0);
    wr(ADDR_NEG_POS, 32'h8000_0001);
    rd(ADDR_NEG_POS, 32'h8000_0001);
    wr(ADDR_NEG_POS, 32'h1);
    wr(ADDR_SOFTCTL, 32'h5);
    pins(5'h00, 1'b0, 1'b1);
    wr(ADDR_SOFTCTL, 32'h0);
    wr(ADDR_HOME, 32'hd);
    homeDone <= 1'b1;
    tick(1);
    homeDone <= 1'b0;
    tick(4);
    chkB(counterClear, 1'b1);
    rd(ADDR_POSITION, 32'h0);
    tick(87);
    chkB(counterClear, 1'b1);
    tick(15);
    chkB(counterClear, 1'b0);
    wr(ADDR_CLEAR, 32'h2);
    tick(3);
    chkB(counterClear, 1'b1);
    wr(ADDR_CLEAR, 32'h4);
    rd(ADDR_CLEAR, 32'h2);
    print_verdict();
  end
endmodule
